// File: src/hsfc_pkg.sv
// Constants for the hub string and feature configuration bank.
// Assumes a byte-wide register port driven by the EEPROM loader and SMBus target.
// Contract
// - Serial bytes returned at string index 1
// - Serial bytes reset from fuse die ID
// - Serial bytes writable only with custom enable
// - Maker text returned, length bytes, index 3
// - Product text returned, length bytes, index 2
// - Spread disable bit turns off spread clocking
// - Spread disable loaded from strap at reset release
// - I2C mode loads spread and reserved bit 0
// - SMBus host may overwrite spread and reserved bits
// - Reserved bits 7:6 loaded or written likewise
// - Read-only reserved bits read zero
// - Text lengths seven bits, reset zero, max 64
package hsfc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SERIAL_BASE = 8'h30;
  localparam logic [7:0] SERIAL_LAST = 8'h4F;
  localparam logic [7:0] MAKER_BASE = 8'h50;
  localparam logic [7:0] MAKER_LAST = 8'h8F;
  localparam logic [7:0] PRODUCT_BASE = 8'h90;
  localparam logic [7:0] PRODUCT_LAST = 8'hCF;
  localparam logic [7:0] FEATURE_ADDR = 8'hF0;
  localparam logic [7:0] RESERVED_CONFIG_F1_F1_ADDR = 8'hF1;
  // ==========================================================
  // Fields and sizes
  localparam int SERIAL_BYTES = 32;
  localparam int TEXT_BYTES = 64;
  localparam logic [7:0] FEATURE_MASK = 8'h01;
  localparam logic [7:0] RESERVED_CONFIG_F1_F1_MASK = 8'hC1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] TEXT_LEN_MAX = 7'h40;
  localparam logic [1:0] IDX_SERIAL = 2'h1;
  localparam logic [1:0] IDX_PRODUCT = 2'h2;
  localparam logic [1:0] IDX_MAKER = 2'h3;
  typedef enum logic [2:0] {
    HSFC_IDLE = 3'b001,
    HSFC_SEND = 3'b010,
    HSFC_LAST = 3'b100
  } hsfc_state_t;
endpackage

// File: src/hsfc_strap_sync.sv
// Two-stage synchroniser for a pin level.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
module hsfc_strap_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic pinSync
);
  logic stage1;
  logic next_stage1;
  logic next_pinSync;
  always_comb begin
    next_stage1 = clkEn ? pinIn : stage1;
    next_pinSync = clkEn ? stage1 : pinSync;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Keeps tracking in reset so the level is ready at release
      stage1 <= pinIn;
      pinSync <= stage1;
    end else begin
      stage1 <= next_stage1;
      pinSync <= next_pinSync;
    end
  end
endmodule

// File: src/hsfc_config_bank.sv
// Byte register bank holding hub strings and feature bits.
// Assumes one writer at a time: EEPROM loader in I2C mode, SMBus target otherwise.
`timescale 1ns/1ps
module hsfc_config_bank (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic i2cMode,
  input wire logic customSerialEnable,
  input wire logic [255:0] fuseDieId,
  input wire logic ssSuspendStrap,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [6:0] makerTextLength,
  input wire logic [6:0] productTextLength,
  input wire logic descReq,
  input wire logic [1:0] descIndex,
  output logic descValid,
  output logic [7:0] descData,
  output logic descLast,
  output logic spreadSpectrumDisable,
  output logic [7:0] reservedConfigF1
);
  // ==========================================================
  // Storage
  logic [7:0] serialIdByteArray [hsfc_pkg::SERIAL_BYTES];
  logic [7:0] makerTextByteArray [hsfc_pkg::TEXT_BYTES];
  logic [7:0] productTextByteArray [hsfc_pkg::TEXT_BYTES];
  logic strapSync;
  logic rstSeen;
  logic [7:0] next_regRdata;
  logic next_ssd;
  logic [7:0] next_reserved_config_f1;
  logic wrSerial;
  logic wrMaker;
  logic wrProduct;
  logic [7:0] offSerial;
  logic [7:0] offMaker;
  logic [7:0] offProduct;

  // Strap passes the synchroniser before use
  hsfc_strap_sync u_strap (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(ssSuspendStrap),
    .pinSync(strapSync)
  );

  always_comb begin
    offSerial = regAddr - hsfc_pkg::SERIAL_BASE;
    offMaker = regAddr - hsfc_pkg::MAKER_BASE;
    offProduct = regAddr - hsfc_pkg::PRODUCT_BASE;
    wrSerial = regWrite && customSerialEnable && regAddr >= hsfc_pkg::SERIAL_BASE
      && regAddr <= hsfc_pkg::SERIAL_LAST;
    wrMaker = regWrite && regAddr >= hsfc_pkg::MAKER_BASE && regAddr <= hsfc_pkg::MAKER_LAST;
    wrProduct = regWrite && regAddr >= hsfc_pkg::PRODUCT_BASE
      && regAddr <= hsfc_pkg::PRODUCT_LAST;
  end

  // ==========================================================
  // Byte arrays, one generate per entry
  genvar gi;
  generate
    for (gi = 0; gi < hsfc_pkg::TEXT_BYTES; gi++) begin : gText
      logic [7:0] nextMaker;
      logic [7:0] nextProduct;
      always_comb begin
        nextMaker = makerTextByteArray[gi];
        nextProduct = productTextByteArray[gi];
        if (clkEn && wrMaker && offMaker[5:0] == 6'(gi)) nextMaker = regWdata;
        if (clkEn && wrProduct && offProduct[5:0] == 6'(gi)) nextProduct = regWdata;
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          makerTextByteArray[gi] <= hsfc_pkg::RESET_BYTE;
          productTextByteArray[gi] <= hsfc_pkg::RESET_BYTE;
        end else begin
          makerTextByteArray[gi] <= nextMaker;
          productTextByteArray[gi] <= nextProduct;
        end
      end
    end
    for (gi = 0; gi < hsfc_pkg::SERIAL_BYTES; gi++) begin : gSerial
      logic [7:0] nextSerial;
      logic loaded;
      always_comb begin
        nextSerial = serialIdByteArray[gi];
        // Fuse value taken after reset release; a reset flop may not load a port
        if (clkEn && !loaded) nextSerial = fuseDieId[gi*8 +: 8];
        else if (clkEn && wrSerial && offSerial[4:0] == 5'(gi)) nextSerial = regWdata;
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          serialIdByteArray[gi] <= hsfc_pkg::RESET_BYTE;
          loaded <= 1'b0;
        end else begin
          serialIdByteArray[gi] <= nextSerial;
          loaded <= loaded | clkEn;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Feature bits
  always_comb begin
    next_ssd = spreadSpectrumDisable;
    next_reserved_config_f1 = reservedConfigF1;
    if (clkEn) begin
      if (!rstSeen) next_ssd = strapSync;
      else if (regWrite && regAddr == hsfc_pkg::FEATURE_ADDR)
        next_ssd = regWdata[0];
      if (regWrite && regAddr == hsfc_pkg::RESERVED_CONFIG_F1_F1_ADDR)
        next_reserved_config_f1 = regWdata & hsfc_pkg::RESERVED_CONFIG_F1_F1_MASK;
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    next_regRdata = regRdata;
    if (clkEn && regRead) begin
      next_regRdata = hsfc_pkg::RESET_BYTE;
      if (regAddr >= hsfc_pkg::SERIAL_BASE && regAddr <= hsfc_pkg::SERIAL_LAST)
        next_regRdata = serialIdByteArray[offSerial[4:0]];
      else if (regAddr >= hsfc_pkg::MAKER_BASE && regAddr <= hsfc_pkg::MAKER_LAST)
        next_regRdata = makerTextByteArray[offMaker[5:0]];
      else if (regAddr >= hsfc_pkg::PRODUCT_BASE && regAddr <= hsfc_pkg::PRODUCT_LAST)
        next_regRdata = productTextByteArray[offProduct[5:0]];
      else if (regAddr == hsfc_pkg::FEATURE_ADDR)
        next_regRdata = {7'h00, spreadSpectrumDisable} & hsfc_pkg::FEATURE_MASK;
      else if (regAddr == hsfc_pkg::RESERVED_CONFIG_F1_F1_ADDR)
        next_regRdata = reservedConfigF1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      spreadSpectrumDisable <= 1'b0;
      reservedConfigF1 <= hsfc_pkg::RESET_BYTE;
      regRdata <= hsfc_pkg::RESET_BYTE;
      rstSeen <= 1'b0;
    end else begin
      spreadSpectrumDisable <= next_ssd;
      reservedConfigF1 <= next_reserved_config_f1;
      regRdata <= next_regRdata;
      rstSeen <= rstSeen | clkEn;
    end
  end

  // ==========================================================
  // Descriptor streaming
  hsfc_pkg::hsfc_state_t state;
  hsfc_pkg::hsfc_state_t next_state;
  logic [6:0] count;
  logic [6:0] next_count;
  logic [6:0] length;
  logic [6:0] next_length;
  logic [1:0] index;
  logic [1:0] next_index;
  logic next_descValid;
  logic [7:0] next_descData;
  logic next_descLast;
  logic [6:0] reqLen;
  logic [7:0] curByte;

  always_comb begin
    case (descIndex)
      hsfc_pkg::IDX_SERIAL: reqLen = 7'(hsfc_pkg::SERIAL_BYTES);
      hsfc_pkg::IDX_PRODUCT: reqLen = productTextLength;
      hsfc_pkg::IDX_MAKER: reqLen = makerTextLength;
      default: reqLen = 7'h00;
    endcase
    if (reqLen > hsfc_pkg::TEXT_LEN_MAX) reqLen = hsfc_pkg::TEXT_LEN_MAX;
    case (index)
      hsfc_pkg::IDX_SERIAL: curByte = serialIdByteArray[count[4:0]];
      hsfc_pkg::IDX_PRODUCT: curByte = productTextByteArray[count[5:0]];
      default: curByte = makerTextByteArray[count[5:0]];
    endcase
  end

  always_comb begin
    next_state = state;
    next_count = count;
    next_length = length;
    next_index = index;
    next_descValid = 1'b0;
    next_descData = descData;
    next_descLast = 1'b0;
    if (clkEn) begin
      case (state)
        hsfc_pkg::HSFC_IDLE: begin
          if (descReq && reqLen != 7'h00) begin
            next_state = hsfc_pkg::HSFC_SEND;
            next_count = 7'h00;
            next_length = reqLen;
            next_index = descIndex;
          end
        end
        hsfc_pkg::HSFC_SEND: begin
          next_descValid = 1'b1;
          next_descData = curByte;
          next_count = count + 7'h01;
          if (count + 7'h01 == length) begin
            next_descLast = 1'b1;
            next_state = hsfc_pkg::HSFC_LAST;
          end
        end
        hsfc_pkg::HSFC_LAST: next_state = hsfc_pkg::HSFC_IDLE;
        default: next_state = hsfc_pkg::HSFC_IDLE;
      endcase
    end else begin
      next_descValid = descValid;
      next_descLast = descLast;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= hsfc_pkg::HSFC_IDLE;
      count <= 7'h00;
      length <= 7'h00;
      index <= 2'h0;
      descValid <= 1'b0;
      descData <= hsfc_pkg::RESET_BYTE;
      descLast <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      length <= next_length;
      index <= next_index;
      descValid <= next_descValid;
      descData <= next_descData;
      descLast <= next_descLast;
    end
  end

  // ==========================================================
  // Checks
  chk_serial_locked: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && regWrite && !customSerialEnable && rstSeen && gSerial[0].loaded
    && regAddr == hsfc_pkg::SERIAL_BASE |=> $stable(serialIdByteArray[0]))
    else $error("serial byte changed while custom enable low");
  chk_feature_write: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && rstSeen && regWrite && regAddr == hsfc_pkg::FEATURE_ADDR
    |=> spreadSpectrumDisable == $past(regWdata[0]))
    else $error("spread disable write lost");
  chk_reserved_config_f1_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (reservedConfigF1 & ~hsfc_pkg::RESERVED_CONFIG_F1_F1_MASK) == 8'h00)
    else $error("reserved read-only bits nonzero");
  chk_strap_load: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && !rstSeen |=> spreadSpectrumDisable == $past(strapSync))
    else $error("strap not loaded at reset release");
  chk_maker_count: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && state == hsfc_pkg::HSFC_IDLE && descReq && descIndex == hsfc_pkg::IDX_MAKER
    && makerTextLength == 7'h02 ##1 clkEn[*2] |-> descValid && !descLast
    ##1 descValid && descLast)
    else $error("maker string byte count wrong");
  chk_product_len: assert property (@(posedge mclk) disable iff (sys_rst)
    descLast && index == hsfc_pkg::IDX_PRODUCT |-> count == length)
    else $error("product string length wrong");
  chk_len_cap: assert property (@(posedge mclk) disable iff (sys_rst)
    length <= hsfc_pkg::TEXT_LEN_MAX)
    else $error("string length over limit");
  chk_serial_data: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && state == hsfc_pkg::HSFC_SEND && index == hsfc_pkg::IDX_SERIAL && count == 7'h00
    |=> descData == $past(serialIdByteArray[0]))
    else $error("serial first byte wrong");
  cov_serial: cover property (@(posedge mclk) descLast && index == hsfc_pkg::IDX_SERIAL);
  cov_maker: cover property (@(posedge mclk) descLast && index == hsfc_pkg::IDX_MAKER);
  cov_product: cover property (@(posedge mclk) descLast && index == hsfc_pkg::IDX_PRODUCT);
  cov_reserved_config_f1: cover property (@(posedge mclk) reservedConfigF1 == hsfc_pkg::RESERVED_CONFIG_F1_F1_MASK);
endmodule

// File: test/hsfc_host_model.sv
// SMBus host or EEPROM loader model: byte writes and reads on the bank port.
// Assumes mclk from the bench and one access at a time.
`timescale 1ns/1ps
module hsfc_host_model (
  input wire logic mclk,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  // ==========================================================
  // Bus cycles
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Text bytes stored as given; UTF-16LE is the caller's duty
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge mclk);
    #1;
    regWrite = 1'b0;
    // Released lines show the inverse, never a stale value
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge mclk);
    #1;
    d = regRdata;
    regRead = 1'b0;
    regAddr = ~a;
  endtask
  // Normal operation leaves spread and reserved bit 0 at zero
  task automatic park();
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h00);
  endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the string and feature bank.
// Assumes the host model as the only register writer.
`timescale 1ns/1ps
module testbench;
  logic mclk, sys_rst, clkEn, i2cMode, customSerialEnable, ssSuspendStrap;
  logic regWrite, regRead, descReq, descValid, descLast, spreadSpectrumDisable;
  logic [255:0] fuseDieId;
  logic [7:0] regAddr, regWdata, regRdata, descData, reservedConfigF1, rb;
  logic [6:0] makerTextLength, productTextLength;
  logic [1:0] descIndex, ix;
  logic [7:0] mk [64];
  logic [7:0] pd [64];
  logic [7:0] sn [32];
  logic [7:0] zs [4] = '{8'h50, 8'hCF, 8'hF1, 8'hD0};
  integer seed = 32'h03614FAB;
  int failures = 0;
  int comparisons = 0;
  hsfc_config_bank i_dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .i2cMode(i2cMode),
    .customSerialEnable(customSerialEnable), .fuseDieId(fuseDieId),
    .ssSuspendStrap(ssSuspendStrap), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .makerTextLength(makerTextLength), .productTextLength(productTextLength),
    .descReq(descReq), .descIndex(descIndex), .descValid(descValid), .descData(descData),
    .descLast(descLast), .spreadSpectrumDisable(spreadSpectrumDisable),
    .reservedConfigF1(reservedConfigF1));
  hsfc_host_model i_host (.mclk(mclk), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
  // ==========================================================
  // Clock, checks, expectations
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic int exp_len(input logic [1:0] idx, input logic [6:0] len);
    if (idx == 2'h1) return hsfc_pkg::SERIAL_BYTES;
    if (idx == 2'h0) return 0;
    return (int'(len) > hsfc_pkg::TEXT_BYTES) ? hsfc_pkg::TEXT_BYTES : int'(len);
  endfunction
  function automatic logic [7:0] exp_byte(input logic [1:0] idx, input int n);
    if (idx == 2'h1) return sn[n];
    if (idx == 2'h2) return pd[n];
    return mk[n];
  endfunction
  // ==========================================================
  // Procedures
  task automatic do_reset(input logic strap);
    ssSuspendStrap = strap;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 32; i++) sn[i] = fuseDieId[8*i +: 8];
    repeat (2) @(posedge mclk);
    i_host.rd(8'hF0, rb);
    chk("feature", {7'h00, strap}, rb);
    foreach (zs[k]) begin
      i_host.rd(zs[k], rb);
      chk("resetByte", 8'h00, rb);
    end
  endtask
  // Serial bytes must hold the fuse copy and refuse writes while locked
  task automatic serial_pass();
    for (int i = 0; i < 32; i++) begin
      i_host.wr(8'h30 + 8'(i), ~sn[i]);
      i_host.rd(8'h30 + 8'(i), rb);
      chk("serial", sn[i], rb);
    end
  endtask
  task automatic desc(input logic [1:0] idx, input logic [6:0] len);
    int n;
    n = 0;
    makerTextLength = (idx == 2'h3) ? len : len ^ 7'h15;
    productTextLength = (idx == 2'h2) ? len : len ^ 7'h15;
    @(posedge mclk);
    #1;
    descIndex = idx;
    descReq = 1'b1;
    @(posedge mclk);
    #1;
    descReq = 1'b0;
    // Bounded wait; a missing last byte shows as a count mismatch
    for (int w = 0; w < 80; w++) begin
      if (descValid === 1'b1) begin
        chk("descData", exp_byte(idx, n), descData);
        chk("descLast", {7'h00, n == exp_len(idx, len) - 1}, {7'h00, descLast});
        n++;
        if (descLast === 1'b1) break;
      end
      @(posedge mclk);
      #1;
    end
    chk("descCount", 8'(exp_len(idx, len)), 8'(n));
    // A stream that never ends is a hang: count it and report at once
    if (exp_len(idx, len) > 0 && descLast !== 1'b1) begin
      failures++;
      give_verdict();
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask
  initial begin
    clkEn = 1'b1;
    i2cMode = 1'b1;
    customSerialEnable = 1'b0;
    descReq = 1'b0;
    descIndex = 2'h1;
    makerTextLength = 7'h00;
    productTextLength = 7'h00;
    for (int i = 0; i < 8; i++) fuseDieId[32*i +: 32] = $random(seed);
    do_reset(1'b1);
    chk("ssDis", 8'h01, {7'h00, spreadSpectrumDisable});
    serial_pass();
    customSerialEnable = 1'b1;
    for (int i = 0; i < 64; i++) begin
      i2cMode = i[0];
      mk[i] = 8'($random(seed));
      pd[i] = 8'($random(seed));
      i_host.wr(8'h50 + 8'(i), mk[i]);
      i_host.wr(8'h90 + 8'(i), pd[i]);
      if (i < 32) begin
        sn[i] = 8'($random(seed));
        i_host.wr(8'h30 + 8'(i), sn[i]);
      end
    end
    desc(2'h3, 7'h00);
    desc(2'h2, 7'h00);
    desc(2'h1, 7'h00);
    desc(2'h3, 7'h01);
    desc(2'h3, 7'h02);
    desc(2'h0, 7'h10);
    desc(2'h2, 7'h40);
    desc(2'h3, 7'h7F);
    repeat (8) begin
      ix = 2'($random(seed));
      if (ix == 2'h0) ix = 2'h2;
      desc(ix, 7'($random(seed)));
    end
    i2cMode = 1'b0;
    i_host.wr(8'hF0, 8'hFF);
    i_host.rd(8'hF0, rb);
    chk("feature", 8'h01, rb);
    chk("ssDis", 8'h01, {7'h00, spreadSpectrumDisable});
    i_host.wr(8'hF1, 8'hFF);
    i_host.rd(8'hF1, rb);
    chk("rsvdF1", 8'hC1, rb);
    i2cMode = 1'b1;
    i_host.wr(8'hF1, 8'h40);
    chk("rsvdOut", 8'h40, reservedConfigF1);
    clkEn = 1'b0;
    i_host.wr(8'hF1, 8'h81);
    clkEn = 1'b1;
    chk("frozen", 8'h40, reservedConfigF1);
    i_host.park();
    chk("ssDis", 8'h00, {7'h00, spreadSpectrumDisable});
    customSerialEnable = 1'b0;
    i_host.wr(8'hF0, 8'h01);
    do_reset(1'b0);
    chk("ssDis", 8'h00, {7'h00, spreadSpectrumDisable});
    serial_pass();
    give_verdict();
  end
endmodule
